// ---- dv/irq_regs_chk.sv ----
`timescale 1ns/100ps
module irq_regs_chk
    import irq_enable_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire irq_enable_pkg::apb_req_type apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire irq_enable_pkg::event_in_type events,
    input wire logic irq
);
    logic [31:0] en_ff;
    wire logic [11:0] a = apb_req.paddr;
    wire logic tk = apb_req.psel && apb_req.penable && !pready;
    wire logic rs = tk && !apb_req.pwrite && (a == enable_set_offset || a == enable_clear_offset);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            en_ff <= '0;
        else if (tk && apb_req.pwrite && a == enable_set_offset)
            en_ff <= en_ff | (apb_req.pwdata & event_mask);
        else if (tk && apb_req.pwrite && a == enable_clear_offset)
            en_ff <= en_ff & ~apb_req.pwdata;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rd; rs |=> pready && prdata == en_ff; endproperty
    a_rd: assert property (p_rd) else $error("bad readback");
    property p_wait; tk |=> pready ##1 !pready; endproperty
    a_wait: assert property (p_wait) else $error("bad ready");
    property p_halt; events.halted && en_ff[1] |-> ##[1:2] irq; endproperty
    a_halt: assert property (p_halt) else $error("no irq");
    property p_rx; events.rx_byte_ready && en_ff[2] |-> ##[1:2] irq; endproperty
    a_rx: assert property (p_rx) else $error("no irq");
    property p_tx; events.tx_byte_sent && en_ff[7] |-> ##[1:2] irq; endproperty
    a_tx: assert property (p_tx) else $error("no irq");
    property p_err; events.error && en_ff[9] |-> ##[1:2] irq; endproperty
    a_err: assert property (p_err) else $error("no irq");
    property p_bb; events.byte_start && en_ff[14] |-> ##[1:2] irq; endproperty
    a_bb: assert property (p_bb) else $error("no irq");
    property p_off; en_ff == '0 && !tk |=> !irq; endproperty
    a_off: assert property (p_off) else $error("stray irq");
    c_rd: cover property (rs);
    c_irq: cover property ($rose(irq));
    c_halt: cover property (events.halted && en_ff[1]);
endmodule
bind two_wire_irq_enable_regs irq_regs_chk u_irq_regs_chk (.pclk, .presetn, .apb_req, .prdata,
    .pready, .events, .irq);

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import irq_enable_pkg::*;
    localparam logic [11:0] set_a = enable_set_offset, clr_a = enable_clear_offset;
    localparam logic [11:0] sts_a = event_status_offset, ctl_a = event_control_offset;
    logic pclk, presetn, pready, pslverr, irq;
    logic [31:0] prdata, m;
    apb_req_type req;
    event_in_type ev;
    int n_errors = 0, checked = 0;
    int pos[5] = '{1, 2, 7, 9, 14};
    two_wire_irq_enable_regs u_two_wire_irq_enable_regs (.pclk, .presetn, .apb_req(req),
        .prdata, .pready, .pslverr, .events(ev), .irq);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        chk(pslverr, {31'h00000000, !(a inside {set_a, clr_a, sts_a, ctl_a})});
        if (!w)
            chk(prdata, d);
        req <= '0;
        @(posedge pclk);
    endtask
    task automatic pulse(input logic [5:0] v);
        ev <= v;
        @(posedge pclk);
        ev <= '0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        #200000;
        n_errors++;
        wrap_up();
    end
    initial
    begin
        presetn = 1'b0;
        req = '0;
        ev = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, set_a, '0);
        foreach (pos[i])
        begin
            m = 32'h1 << pos[i];
            pulse(6'h20 >> i);
            chk(irq, 1'b0);
            apb(1, set_a, m);
            apb(1, clr_a, '0);
            apb(0, clr_a, m);
            chk(irq, 1'b1);
            apb(1, clr_a, m);
            apb(0, set_a, '0);
            apb(1, sts_a, '1);
            apb(1, set_a, m);
            pulse(6'h20 >> i);
            chk(irq, 1'b1);
            apb(1, clr_a, '1);
            apb(1, sts_a, '1);
        end
        apb(1, set_a, 32'h0004_0000);
        pulse(6'h01);
        apb(0, sts_a, '0);
        apb(1, ctl_a, 32'h1);
        pulse(6'h01);
        apb(0, sts_a, 32'h0004_0000);
        chk(irq, 1'b1);
        apb(1, set_a, '1);
        apb(0, clr_a, 32'h0004_4286);
        apb(0, 12'h400, '0);
        wrap_up();
    end
endmodule

// ---- logic/event_status_bank.sv ----
`timescale 1ns/100ps
module event_status_bank
    import irq_enable_pkg::*;
#(
    parameter int width = 32
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Set and clear pulses
    input wire logic [width-1:0] set_bits,
    input wire logic [width-1:0] clear_bits,
    // Sticky state
    output logic [width-1:0] flags_ff
);

    initial
    begin
        if (width < 19)
        begin
            $error("width too small for event positions");
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_ff <= status_reset[width-1:0];
        end
        else
        begin
            flags_ff <= (flags_ff & ~clear_bits) | set_bits;
        end
    end

endmodule

// ---- logic/irq_enable_pkg.sv ----
package irq_enable_pkg;

    // Register byte addresses
    localparam logic [11:0] enable_set_offset = 12'h304;
    localparam logic [11:0] enable_clear_offset = 12'h308;
    localparam logic [11:0] event_status_offset = 12'h30C;
    localparam logic [11:0] event_control_offset = 12'h310;

    // Enable bit positions
    localparam int halted_pos = 1;
    localparam int rx_byte_ready_pos = 2;
    localparam int tx_byte_sent_pos = 7;
    localparam int error_pos = 9;
    localparam int byte_boundary_pos = 14;
    localparam int suspended_pos = 18;

    // Reset values
    localparam logic [31:0] enable_reset = 32'h00000000;
    localparam logic [31:0] status_reset = 32'h00000000;

    // Mask of implemented event bits
    localparam logic [31:0] event_mask = 32'h00044286;

    // Control register field: suspend request
    localparam int suspend_req_pos = 0;

    // Controller event inputs
    typedef struct packed {
        logic halted;
        logic rx_byte_ready;
        logic tx_byte_sent;
        logic error;
        logic byte_start;
        logic read_ack_done;
    } event_in_type;

    // APB request
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

endpackage

// ---- logic/two_wire_irq_enable_regs.sv ----
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// - Writing one to bit 1 of the set register enables the halted interrupt; reads show it.
// - Writing one to a clear register bit disables that enable; it reads the same state.
// - The received byte enable sits at bit 2 in both registers.
// - The sent byte enable sits at bit 7 in both registers.
// - The error enable sits at bit 9 in both registers.
// - The byte boundary enable sits at bit 14 in both registers.
// - The suspended enable sits at bit 18 in both registers.
// - Suspended is raised right after a read ack only when a suspend was requested before.
// - The byte boundary event is raised ahead of every byte sent or received.
module two_wire_irq_enable_regs
    import irq_enable_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire irq_enable_pkg::apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Controller events
    input wire irq_enable_pkg::event_in_type events,
    // Interrupt
    output logic irq
);
    import irq_enable_pkg::*;

    logic [31:0] enable_ff;
    logic [31:0] nxt_enable;
    logic [31:0] status;
    logic [31:0] event_set;
    logic [31:0] status_clear;
    logic suspend_req_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic access;
    logic wr;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == enable_set_offset) || (a == enable_clear_offset)
            || (a == event_status_offset) || (a == event_control_offset);
    endfunction

    // Access phase takes two cycles; pready rises one cycle after penable
    assign access = apb_req.psel && apb_req.penable && !pready_ff;
    assign wr = access && apb_req.pwrite && mapped(apb_req.paddr);

    // Enable set and clear; zero bits leave state alone
    always_comb
    begin
        nxt_enable = enable_ff;
        if (wr && apb_req.paddr == enable_set_offset)
        begin
            nxt_enable = enable_ff | (apb_req.pwdata & event_mask);
        end
        else if (wr && apb_req.paddr == enable_clear_offset)
        begin
            nxt_enable = enable_ff & ~(apb_req.pwdata & event_mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_ff <= enable_reset;
        end
        else
        begin
            enable_ff <= nxt_enable;
        end
    end

    // Suspend request held until the read ack consumes it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            suspend_req_ff <= 1'b0;
        end
        else if (wr && apb_req.paddr == event_control_offset)
        begin
            suspend_req_ff <= apb_req.pwdata[suspend_req_pos];
        end
        else if (events.read_ack_done && suspend_req_ff)
        begin
            suspend_req_ff <= 1'b0;
        end
    end

    // Event positions shared by status and enables
    always_comb
    begin
        event_set = 32'h00000000;
        event_set[halted_pos] = events.halted;
        event_set[rx_byte_ready_pos] = events.rx_byte_ready;
        event_set[tx_byte_sent_pos] = events.tx_byte_sent;
        event_set[error_pos] = events.error;
        event_set[byte_boundary_pos] = events.byte_start;
        event_set[suspended_pos] = events.read_ack_done && suspend_req_ff;
    end

    assign status_clear = (wr && apb_req.paddr == event_status_offset)
        ? (apb_req.pwdata & event_mask) : 32'h00000000;

    event_status_bank #(
        .width(32)
    ) u_status (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(event_set),
        .clear_bits(status_clear),
        .flags_ff(status)
    );

    // Bus answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else
        begin
            pready_ff <= access;
            pslverr_ff <= access && !mapped(apb_req.paddr);
            prdata_ff <= 32'h00000000;
            if (access && !apb_req.pwrite)
            begin
                unique case (apb_req.paddr)
                    enable_set_offset: prdata_ff <= enable_ff;
                    enable_clear_offset: prdata_ff <= enable_ff;
                    event_status_offset: prdata_ff <= status;
                    event_control_offset: prdata_ff <= {31'h00000000, suspend_req_ff};
                    default: prdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    // Interrupt level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= |(status & nxt_enable);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;

endmodule
